// ---- src/utc_ctrl.v ----
// Serial control block: control registers, transmitter, pin ownership, wake-up and interrupt
// Overview of operation
// - Control register is readable and writable at any time.
// - Bit 7 enables an interrupt while the transmit buffer is empty.
// - Bit 6 enables an interrupt while transmission is complete.
// - Bit 5 enables an interrupt while the receive buffer is full.
// - Bit 4 enables an interrupt while the idle-line flag is set.
// - Bit 3 turns the transmitter on and claims the transmit pin.
// - In single-wire mode the direction bit sets whether the pin drives.
// - Toggling transmitter enable off then on mid-transmission queues one idle character.
// - Pin stays owned until pending data, idle or break finishes.
// - Bit 2 turns the receiver on; off returns receive pin to GPIO.
// - Loopback releases the receive pin to GPIO even with receiver on.
// - Writing bit 1 puts the receiver in standby awaiting wake-up.
// - Wake-up is idle line or a set data MSB, by wake select.
// - Hardware clears standby on wake-up; software can set or clear it.
// - While break bit is 1, breaks of 10/11 or 13/14 bits repeat.
// - A second break may be queued before software clears the bit.
// - Loopback feeds transmitter to receiver; source select gives single-wire.
// - Character length select adds a ninth data bit before stop.
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`default_nettype none
`include "utc_map.vh"
module utc_ctrl #(
	parameter BAUD_W = 13
) (
	input  wire        clk,
	input  wire        rst,
	input  wire [11:0] paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        txd_in,
	output reg         txd_out,
	output reg         txd_oe_n,
	output reg         txd_owned,
	input  wire        rxd_in,
	output reg         rxd_owned,
	output reg         irq
);
	localparam TX_IDLE = 4'b0001;
	localparam TX_DATA = 4'b0010;
	localparam TX_BRK  = 4'b0100;
	localparam TX_PRE  = 4'b1000;

	reg [7:0] ctrl_two_q;
	reg [7:0] ctrl_one_q;
	reg [BAUD_W-1:0] baud_q;
	reg [8:0] tx_buf_q;
	reg       tx_empty_q;
	reg [8:0] rx_data_q;
	reg       rx_full_q;
	reg       quiet_q;
	reg       quiet_arm_q;
	reg [3:0] tx_state_q;
	reg [10:0] tx_shift_q;
	reg [4:0] tx_cnt_q;
	reg       idle_pend_q;
	reg       brk_pend_q;
	reg       txd_s1_q, txd_s2_q, rxd_s1_q, rxd_s2_q;
	reg       tx_line_q;
	reg       tx_tail_q;

	wire tx_empty_ie = ctrl_two_q[`UTC_BIT_TX_EMPTY_IE];
	wire tx_done_ie  = ctrl_two_q[`UTC_BIT_TX_DONE_IE];
	wire rx_full_ie  = ctrl_two_q[`UTC_BIT_RX_FULL_IE];
	wire quiet_ie    = ctrl_two_q[`UTC_BIT_QUIET_IE];
	wire tx_on       = ctrl_two_q[`UTC_BIT_TX_ON];
	wire rx_on       = ctrl_two_q[`UTC_BIT_RX_ON];
	wire rx_standby  = ctrl_two_q[`UTC_BIT_RX_STANDBY];
	wire queue_break = ctrl_two_q[`UTC_BIT_QUEUE_BREAK];
	wire loopback_sel   = ctrl_one_q[`UTC_BIT_LOOPBACK];
	wire rx_source_sel  = ctrl_one_q[`UTC_BIT_RX_SOURCE];
	wire nine_bit       = ctrl_one_q[`UTC_BIT_NINE_BIT];
	wire wake_sel       = ctrl_one_q[`UTC_BIT_WAKE_SEL];
	wire long_break_sel = ctrl_one_q[`UTC_BIT_LONG_BREAK];
	wire wire_direction = ctrl_one_q[`UTC_BIT_WIRE_DIR];
	wire single_wire = loopback_sel && rx_source_sel;

	function addr_is;
		input [11:0] a;
		input [11:0] b;
		addr_is = (a == b);
	endfunction

	wire access   = psel && penable;
	wire wr       = access && pwrite;
	wire rd       = access && !pwrite;
	wire wr_two   = wr && addr_is(paddr, `UTC_ADDR_CTRL_TWO);
	wire wr_one   = wr && addr_is(paddr, `UTC_ADDR_CTRL_ONE);
	wire wr_data  = wr && addr_is(paddr, `UTC_ADDR_DATA);
	wire wr_baud  = wr && addr_is(paddr, `UTC_ADDR_BAUD);
	wire rd_data  = rd && addr_is(paddr, `UTC_ADDR_DATA);
	wire mapped   = addr_is(paddr, `UTC_ADDR_CTRL_TWO) || addr_is(paddr, `UTC_ADDR_CTRL_ONE) ||
	                addr_is(paddr, `UTC_ADDR_STATUS) || addr_is(paddr, `UTC_ADDR_DATA) ||
	                addr_is(paddr, `UTC_ADDR_BAUD);
	wire new_tx_on = pwdata[`UTC_BIT_TX_ON];
	wire new_brk   = pwdata[`UTC_BIT_QUEUE_BREAK];

	// The last bit of a character or break is still on the line for one bit time after the state returns to idle
	wire tx_active   = (tx_state_q != TX_IDLE) || tx_tail_q;
	wire tx_finished = tx_empty_q && !tx_active && !idle_pend_q && !brk_pend_q;
	// Pin stays ours while anything queued is still going out
	wire tx_hold     = tx_on || tx_active || idle_pend_q || brk_pend_q;

	// Receiver input: internal loop, shared pin, or receive pin
	wire rx_line = loopback_sel ? (rx_source_sel ? txd_s2_q : tx_line_q) : rxd_s2_q;

	wire       tick;
	wire       rx_done;
	wire [8:0] rx_char;
	wire       rx_idle;
	wire       rx_msb;

	utc_baud_tick #(.DIV_W(BAUD_W)) u_tick (
		.clk     (clk),
		.rst     (rst),
		.divisor (baud_q),
		.tick    (tick)
	);

	utc_rx_frame u_rx (
		.clk       (clk),
		.rst       (rst),
		.tick      (tick),
		.enable    (rx_on),
		.nine_bit  (nine_bit),
		.line_in   (rx_line),
		.char_done (rx_done),
		.char_data (rx_char),
		.idle_seen (rx_idle),
		.msb_one   (rx_msb)
	);

	// Wake-up detection follows the selected condition
	wire wake_hit = wake_sel ? (rx_done && rx_msb) : rx_idle;

	always @(posedge clk) begin
		if (rst) begin
			txd_s1_q <= 1'b1;
			txd_s2_q <= 1'b1;
			rxd_s1_q <= 1'b1;
			rxd_s2_q <= 1'b1;
		end else begin
			txd_s1_q <= txd_in;
			txd_s2_q <= txd_s1_q;
			rxd_s1_q <= rxd_in;
			rxd_s2_q <= rxd_s1_q;
		end
	end

	// Control register two
	always @(posedge clk) begin
		if (rst) begin
			ctrl_two_q <= `UTC_RESET_BYTE;
		end else if (wr_two) begin
			ctrl_two_q <= pwdata[7:0];
		end else if (rx_standby && wake_hit) begin
			ctrl_two_q[`UTC_BIT_RX_STANDBY] <= 1'b0;
		end
	end

	always @(posedge clk) begin
		if (rst) begin
			ctrl_one_q <= `UTC_RESET_BYTE;
			baud_q <= `UTC_BAUD_RESET;
		end else begin
			if (wr_one)
				ctrl_one_q <= pwdata[7:0];
			if (wr_baud)
				baud_q <= pwdata[BAUD_W-1:0];
		end
	end

	// Receive side flags; standby suppresses capture
	always @(posedge clk) begin
		if (rst) begin
			rx_data_q <= 9'h000;
			rx_full_q <= 1'b0;
			quiet_q <= 1'b0;
			quiet_arm_q <= 1'b0;
		end else begin
			if (rx_done && !rx_standby) begin
				rx_data_q <= rx_char;
				rx_full_q <= 1'b1;
				quiet_arm_q <= 1'b1;
			end else if (rd_data) begin
				rx_full_q <= 1'b0;
			end
			// Idle is flagged once per burst of activity; the set beats a clear
			if (rx_idle && quiet_arm_q && !rx_standby) begin
				quiet_q <= 1'b1;
				quiet_arm_q <= 1'b0;
			end else if (rd_data) begin
				quiet_q <= 1'b0;
			end
		end
	end

	// Transmitter, queued idle and queued break
	always @(posedge clk) begin
		if (rst) begin
			tx_state_q <= TX_IDLE;
			tx_shift_q <= 11'h7ff;
			tx_cnt_q <= 5'h00;
			tx_buf_q <= 9'h000;
			tx_empty_q <= 1'b1;
			idle_pend_q <= 1'b0;
			brk_pend_q <= 1'b0;
			tx_line_q <= 1'b1;
			tx_tail_q <= 1'b0;
		end else begin
			if (wr_data) begin
				tx_buf_q <= pwdata[8:0];
				tx_empty_q <= 1'b0;
			end
			if (wr_two && tx_on && !new_tx_on && tx_active)
				idle_pend_q <= 1'b1;
			if (wr_two && !queue_break && new_brk)
				brk_pend_q <= 1'b1;
			if (tick) begin
				tx_tail_q <= (tx_state_q != TX_IDLE) && (tx_cnt_q == 5'h01);
				case (tx_state_q)
				TX_IDLE: begin
					tx_line_q <= 1'b1;
					if (brk_pend_q || (queue_break && tx_on)) begin
						brk_pend_q <= 1'b0;
						tx_state_q <= TX_BRK;
						tx_cnt_q <= (long_break_sel ? `UTC_BREAK_LONG : `UTC_BREAK_SHORT) +
						            {4'h0, nine_bit};
					end else if (idle_pend_q && tx_on) begin
						idle_pend_q <= 1'b0;
						tx_state_q <= TX_PRE;
						tx_cnt_q <= `UTC_BREAK_SHORT + {4'h0, nine_bit};
					end else if (!tx_empty_q && tx_on && !wr_data) begin
						tx_empty_q <= 1'b1;
						tx_state_q <= TX_DATA;
						tx_shift_q <= nine_bit ? {1'b1, tx_buf_q, 1'b0} : {2'b11, tx_buf_q[7:0], 1'b0};
						tx_cnt_q <= `UTC_BREAK_SHORT + {4'h0, nine_bit};
					end else if (!tx_on) begin
						idle_pend_q <= 1'b0;
					end
				end
				TX_DATA: begin
					tx_line_q <= tx_shift_q[0];
					tx_shift_q <= {1'b1, tx_shift_q[10:1]};
					tx_cnt_q <= tx_cnt_q - 5'h01;
					if (tx_cnt_q == 5'h01)
						tx_state_q <= TX_IDLE;
				end
				TX_BRK: begin
					// Bit still set at the end re-queues; a set-and-clear mid-break can add one more
					tx_line_q <= 1'b0;
					tx_cnt_q <= tx_cnt_q - 5'h01;
					if (tx_cnt_q == 5'h01)
						tx_state_q <= TX_IDLE;
				end
				TX_PRE: begin
					tx_line_q <= 1'b1;
					tx_cnt_q <= tx_cnt_q - 5'h01;
					if (tx_cnt_q == 5'h01)
						tx_state_q <= TX_IDLE;
				end
				default: tx_state_q <= TX_IDLE;
				endcase
			end
		end
	end

	// Pin ownership and drive
	always @(posedge clk) begin
		if (rst) begin
			txd_out <= 1'b1;
			txd_oe_n <= 1'b1;
			txd_owned <= 1'b0;
			rxd_owned <= 1'b0;
		end else begin
			txd_out <= tx_line_q;
			txd_owned <= tx_hold || (single_wire && rx_on);
			if (single_wire)
				txd_oe_n <= !(tx_hold && wire_direction);
			else
				txd_oe_n <= !tx_hold;
			rxd_owned <= rx_on && !loopback_sel;
		end
	end

	// Interrupt request: each flag gated by its enable
	always @(posedge clk) begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= (tx_empty_q && tx_empty_ie) ||
			       (tx_finished && tx_done_ie) ||
			       (rx_full_q && rx_full_ie) ||
			       (quiet_q && quiet_ie);
	end

	// APB slave: no wait states, error on unmapped address
	always @(posedge clk) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			prdata <= 32'h00000000;
			if (psel && !penable && !pwrite) begin
				if (addr_is(paddr, `UTC_ADDR_CTRL_TWO))
					prdata <= {24'h000000, ctrl_two_q};
				else if (addr_is(paddr, `UTC_ADDR_CTRL_ONE))
					prdata <= {24'h000000, ctrl_one_q};
				else if (addr_is(paddr, `UTC_ADDR_STATUS))
					prdata <= {24'h000000, tx_empty_q, tx_finished, rx_full_q, quiet_q, 4'h0};
				else if (addr_is(paddr, `UTC_ADDR_DATA))
					prdata <= {23'h0, rx_data_q};
				else if (addr_is(paddr, `UTC_ADDR_BAUD))
					prdata <= {{(32-BAUD_W){1'b0}}, baud_q};
			end
		end
	end
endmodule // utc_ctrl
`default_nettype wire

// ---- include/utc_map.vh ----
// Register map and constants for the second serial control register block
`ifndef UTC_MAP_VH
`define UTC_MAP_VH
`define UTC_ADDR_CTRL_TWO   12'h000
`define UTC_ADDR_CTRL_ONE   12'h004
`define UTC_ADDR_STATUS     12'h008
`define UTC_ADDR_DATA       12'h00c
`define UTC_ADDR_BAUD       12'h010
`define UTC_ADDR_W          12
`define UTC_BIT_TX_EMPTY_IE 7
`define UTC_BIT_TX_DONE_IE  6
`define UTC_BIT_RX_FULL_IE  5
`define UTC_BIT_QUIET_IE    4
`define UTC_BIT_TX_ON       3
`define UTC_BIT_RX_ON       2
`define UTC_BIT_RX_STANDBY  1
`define UTC_BIT_QUEUE_BREAK 0
`define UTC_BIT_LOOPBACK    7
`define UTC_BIT_RX_SOURCE   5
`define UTC_BIT_NINE_BIT    4
`define UTC_BIT_WAKE_SEL    3
`define UTC_BIT_LONG_BREAK  2
`define UTC_BIT_WIRE_DIR    1
`define UTC_RESET_BYTE      8'h00
`define UTC_BAUD_RESET      13'h0004
`define UTC_OVERSAMPLE      5'h10
`define UTC_BREAK_SHORT     5'h0a
`define UTC_BREAK_LONG      5'h0d
`endif

// ---- src/utc_baud_tick.v ----
// Baud tick generator: one pulse per bit time
`default_nettype none
module utc_baud_tick #(
	parameter DIV_W = 13
) (
	input  wire             clk,
	input  wire             rst,
	input  wire [DIV_W-1:0] divisor,
	output reg              tick
);
	reg [DIV_W+3:0] cnt_q;
	wire [DIV_W+3:0] limit = {divisor, 4'h0};
	always @(posedge clk) begin
		if (rst) begin
			cnt_q <= {(DIV_W+4){1'b0}};
			tick  <= 1'b0;
		end else if (divisor == {DIV_W{1'b0}}) begin
			// Zero divisor stops the generator to save power
			cnt_q <= {(DIV_W+4){1'b0}};
			tick  <= 1'b0;
		end else if (cnt_q >= limit - 1'b1) begin
			cnt_q <= {(DIV_W+4){1'b0}};
			tick  <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 1'b1;
			tick  <= 1'b0;
		end
	end
endmodule // utc_baud_tick
`default_nettype wire

// ---- src/utc_rx_frame.v ----
// Receive framer: bit-time sampling, idle detection and wake-up
`default_nettype none
module utc_rx_frame (
	input  wire       clk,
	input  wire       rst,
	input  wire       tick,
	input  wire       enable,
	input  wire       nine_bit,
	input  wire       line_in,
	output reg        char_done,
	output reg  [8:0] char_data,
	output reg        idle_seen,
	output reg        msb_one
);
	reg [3:0] bit_q;
	reg       busy_q;
	reg [3:0] high_q;
	reg [8:0] shift_q;
	wire [3:0] last_bit = nine_bit ? 4'h9 : 4'h8;
	wire [3:0] idle_len = nine_bit ? 4'hb : 4'ha;
	always @(posedge clk) begin
		if (rst || !enable) begin
			bit_q <= 4'h0;
			busy_q <= 1'b0;
			high_q <= 4'h0;
			shift_q <= 9'h000;
			char_done <= 1'b0;
			char_data <= 9'h000;
			idle_seen <= 1'b0;
			msb_one <= 1'b0;
		end else begin
			char_done <= 1'b0;
			idle_seen <= 1'b0;
			if (tick) begin
				high_q <= line_in ? ((high_q == idle_len) ? high_q : high_q + 4'h1) : 4'h0;
				idle_seen <= line_in && (high_q == idle_len - 4'h1);
				if (!busy_q) begin
					if (!line_in) begin
						busy_q <= 1'b1;
						bit_q <= 4'h1;
					end
				end else if (bit_q <= last_bit) begin
					shift_q <= nine_bit ? {line_in, shift_q[8:1]} : {1'b0, line_in, shift_q[7:1]};
					bit_q <= bit_q + 4'h1;
				end else begin
					busy_q <= 1'b0;
					char_done <= 1'b1;
					char_data <= shift_q;
					msb_one <= nine_bit ? shift_q[8] : shift_q[7];
				end
			end
		end
	end
endmodule // utc_rx_frame
`default_nettype wire

// ---- verif/utc_ctrl_monitor.sv ----
// Port checker for the serial control block
`default_nettype none
`include "utc_map.vh"
module utc_ctrl_chk (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        txd_in,
	input wire logic        txd_out,
	input wire logic        txd_oe_n,
	input wire logic        txd_owned,
	input wire logic        rxd_in,
	input wire logic        rxd_owned,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic rst_q;
	always_ff @(posedge clk) rst_q <= rst;
	sequence s_setup; psel && !penable; endsequence
	sequence s_wr(a); psel && penable && pready && pwrite && paddr == a; endsequence
	// Owned outputs are registered from the control bits, so two edges are allowed
	ready_after_setup_a: assert property (s_setup |=> pready) else $error("no ready after setup");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
	err_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
	reset_clear_a: assert property (rst_q |-> !irq && !txd_owned && !rxd_owned && txd_oe_n)
		else $error("outputs not cleared by reset");
	tx_claim_a: assert property (s_wr(`UTC_ADDR_CTRL_TWO) ##0 pwdata[3] |-> ##2 txd_owned)
		else $error("transmit pin not claimed");
	rx_release_a: assert property (s_wr(`UTC_ADDR_CTRL_TWO) ##0 !pwdata[2] |-> ##2 !rxd_owned)
		else $error("receive pin kept with receiver off");
	loop_release_a: assert property (s_wr(`UTC_ADDR_CTRL_ONE) ##0 pwdata[7] |-> ##2 !rxd_owned)
		else $error("receive pin kept in loopback");
	irq_masked_a: assert property (s_wr(`UTC_ADDR_CTRL_TWO) ##0 pwdata[7:4] == 4'h0 |-> ##2 !irq)
		else $error("interrupt with all enables clear");
endmodule // utc_ctrl_chk
bind utc_ctrl utc_ctrl_chk i_utc_ctrl_chk (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd_in(txd_in),
	.txd_out(txd_out), .txd_oe_n(txd_oe_n), .txd_owned(txd_owned), .rxd_in(rxd_in), .rxd_owned(rxd_owned),
	.irq(irq));
`default_nettype wire

// ---- verif/utc_remote.sv ----
// Remote serial node: frame sender, frame and break receiver
`default_nettype none
module utc_remote #(
	parameter int BIT = 16
) (
	input wire logic  clk,
	input wire logic  txd_out,
	input wire logic  txd_oe_n,
	input wire logic  txd_owned,
	output var logic  rxd_in,
	output var logic  txd_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       drv = 1'b1;
	logic [7:0] rx_byte = 8'h00;
	int         run = 0;
	int         low_len = 0;
	int         brk_cnt = 0;
	int         rx_cnt = 0;
	// Released shared line floats high through the pull-up
	assign txd_in = txd_oe_n ? 1'b1 : txd_out;
	assign rxd_in = drv;
	always @(posedge clk) begin
		if (txd_owned && !txd_out)
			run <= run + 1;
		else begin
			if (run > 8 * BIT) begin
				low_len <= run;
				brk_cnt <= brk_cnt + 1;
			end
			run <= 0;
		end
	end
	initial forever begin
		@(negedge txd_out);
		repeat (BIT / 2) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clk);
			rx_byte[i] = txd_out;
		end
		repeat (BIT) @(posedge clk);
		rx_cnt++;
	end
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			drv <= f[i];
			repeat (BIT) @(posedge clk);
		end
	endtask
endmodule // utc_remote
`default_nettype wire

// ---- verif/utc_ctrl_tb.sv ----
// Self-checking bench for the serial control block
`default_nettype none
`include "utc_map.vh"
module utc_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BIT = 16;
	localparam logic [11:0] A2 = `UTC_ADDR_CTRL_TWO;
	localparam logic [11:0] A1 = `UTC_ADDR_CTRL_ONE;
	localparam logic [11:0] AD = `UTC_ADDR_DATA;
	logic        clk = 0;
	logic        rst = 1;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	wire  [31:0] prdata;
	wire         pready, pslverr, txd_in, txd_out, txd_oe_n, txd_owned, rxd_in, rxd_owned, irq;
	int          failures = 0;
	int          compares = 0;
	always #5 clk = ~clk;
	utc_ctrl i_utc_ctrl (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .txd_in(txd_in), .txd_out(txd_out),
		.txd_oe_n(txd_oe_n), .txd_owned(txd_owned), .rxd_in(rxd_in), .rxd_owned(rxd_owned), .irq(irq));
	utc_remote #(.BIT(BIT)) i_utc_remote (.clk(clk), .txd_out(txd_out), .txd_oe_n(txd_oe_n),
		.txd_owned(txd_owned), .rxd_in(rxd_in), .txd_in(txd_in));
	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic apb(logic [11:0] a, logic w, logic [31:0] d, output logic [31:0] r, output logic e);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1;
		@(posedge clk);
		penable <= 1;
		// Only the watchdog ends a wait for the slave
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask
	task automatic wr(logic [11:0] a, logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(a, 1'b1, {24'h0, d}, r, e);
	endtask
	task automatic rd(logic [11:0] a, logic [7:0] x, string s);
		logic [31:0] r;
		logic e;
		apb(a, 1'b0, 32'h0, r, e);
		chk(s, {24'h0, x}, r);
	endtask
	task automatic wait_irq(int lim);
		for (int n = 0; n < lim && irq !== 1'b1; n++) @(posedge clk);
	endtask
	task automatic t_irq();
		wr(A2, 8'h80);
		repeat (2) @(posedge clk);
		chk("irq_tx_empty", 1, irq);
		wr(A2, 8'h40);
		repeat (2) @(posedge clk);
		chk("irq_tx_done", 1, irq);
		wr(A2, 8'h30);
		repeat (2) @(posedge clk);
		chk("irq_masked", 0, irq);
	endtask
	task automatic t_pins();
		wr(A2, 8'h0c);
		repeat (2) @(posedge clk);
		chk("txd_owned", 2, {txd_owned, txd_oe_n});
		chk("rxd_owned", 1, rxd_owned);
		rd(A2, 8'h0c, "ctrl_two");
		wr(A1, 8'h80);
		repeat (2) @(posedge clk);
		chk("rxd_loop", 0, rxd_owned);
		wr(A1, 8'ha0);
		repeat (2) @(posedge clk);
		chk("oe_dir0", 1, txd_oe_n);
		wr(A1, 8'ha2);
		repeat (2) @(posedge clk);
		chk("oe_dir1", 0, txd_oe_n);
		wr(A1, 8'h00);
		wr(A2, 8'h08);
		repeat (2) @(posedge clk);
		chk("rxd_off", 0, rxd_owned);
	endtask
	task automatic t_tx();
		int c0, n;
		c0 = i_utc_remote.rx_cnt;
		wr(AD, 8'ha5);
		// Switch off only once the start bit is out, so the character is really in progress
		for (n = 0; n < 100 && txd_out !== 1'b0; n++) @(posedge clk);
		wr(A2, 8'h00);
		repeat (2) @(posedge clk);
		chk("owned_busy", 1, txd_owned);
		for (n = 0; n < 1000 && i_utc_remote.rx_cnt == c0; n++) @(posedge clk);
		chk("tx_byte", 8'ha5, i_utc_remote.rx_byte);
		repeat (3 * BIT) @(posedge clk);
		chk("owned_done", 0, txd_owned);
		wr(A2, 8'h08);
		c0 = i_utc_remote.rx_cnt;
		wr(AD, 8'h3c);
		for (n = 0; n < 100 && txd_out !== 1'b0; n++) @(posedge clk);
		wr(A2, 8'h00);
		wr(A2, 8'h08);
		wr(AD, 8'h96);
		for (n = 0; n < 1000 && i_utc_remote.rx_cnt == c0; n++) @(posedge clk);
		chk("tx_byte_first", 8'h3c, i_utc_remote.rx_byte);
		// A queued idle character keeps the line high for a whole character before the next start bit
		for (n = 0; n < 400 && txd_out !== 1'b0; n++) @(posedge clk);
		chk("idle_gap", 1, n >= 10 * BIT && n < 400);
		for (n = 0; n < 1000 && i_utc_remote.rx_cnt == c0 + 1; n++) @(posedge clk);
		chk("tx_byte_next", 8'h96, i_utc_remote.rx_byte);
	endtask
	task automatic t_break(logic lng);
		int b0, lo, len;
		lo = lng ? 13 : 10;
		b0 = i_utc_remote.brk_cnt;
		wr(A1, {5'h0, lng, 2'h0});
		wr(A2, 8'h08);
		wr(A2, 8'h09);
		wr(A2, 8'h08);
		for (int n = 0; n < 1000 && i_utc_remote.brk_cnt == b0; n++) @(posedge clk);
		len = i_utc_remote.low_len;
		chk("break_len", 1, len >= lo * BIT - 2 && len <= (lo + 1) * BIT + 2);
		b0 = i_utc_remote.brk_cnt;
		wr(A2, 8'h09);
		for (int n = 0; n < 1000 && i_utc_remote.brk_cnt < b0 + 2; n++) @(posedge clk);
		wr(A2, 8'h08);
		chk("break_repeat", 1, i_utc_remote.brk_cnt >= b0 + 2);
		// One more break may already be queued; let it finish
		repeat (16 * BIT) @(posedge clk);
		wr(A2, 8'h00);
		wr(A1, 8'h00);
	endtask
	task automatic t_rx();
		wr(A2, 8'h24);
		i_utc_remote.send(8'h5a);
		wait_irq(100);
		chk("irq_rx_full", 1, irq);
		rd(AD, 8'h5a, "rx_data");
		wr(A2, 8'h14);
		wait_irq(400);
		chk("irq_quiet", 1, irq);
		wr(A2, 8'h00);
	endtask
	task automatic t_wake();
		logic [31:0] r;
		logic e;
		wr(A1, 8'h08);
		wr(A2, 8'h06);
		i_utc_remote.send(8'h01);
		rd(A2, 8'h06, "standby_kept");
		i_utc_remote.send(8'h81);
		repeat (BIT) @(posedge clk);
		rd(A2, 8'h04, "standby_msb");
		wr(A1, 8'h00);
		wr(A2, 8'h06);
		i_utc_remote.send(8'h01);
		repeat (12 * BIT) @(posedge clk);
		rd(A2, 8'h04, "standby_idle");
		apb(12'h0f0, 1'b0, 32'h0, r, e);
		chk("unmapped_data", 0, r);
		chk("unmapped_err", 1, e);
	endtask
	task automatic final_report();
		if (failures == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		rd(A2, 8'h00, "ctrl_two_rst");
		chk("pins_rst", 3, {irq, txd_owned, rxd_owned, txd_out, txd_oe_n});
		wr(`UTC_ADDR_BAUD, 8'h01);
		t_irq();
		t_pins();
		t_tx();
		t_break(1'b0);
		t_break(1'b1);
		t_rx();
		t_wake();
		final_report();
	end
	initial begin
		#200us;
		failures++;
		final_report();
	end
endmodule // utc_ctrl_tb
`default_nettype wire
